// >>> logic/ssr_mem.sv
// byte-lane storage array with registered read data
`include "ssr_params.svh"
`default_nettype none
module ssr_mem #(
   parameter int ADDR_W = `SSR_ADDR_W,
   parameter int DATA_W = `SSR_DATA_W,
   parameter int LANES = `SSR_LANES
) (
   // clock
   input wire logic clk_in,
   // array port
   ssr_mem_if.mem port
);
   localparam int LANE_W = DATA_W / LANES;

   // no reset: contents survive reset and sleep alike
   logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

   always_ff @(posedge clk_in) begin
      for (int i = 0; i < LANES; i++) begin
         if (port.lane_we[i]) begin
            cells[port.addr][i*LANE_W +: LANE_W] <= port.wdata[i*LANE_W +: LANE_W];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (port.rd_en) begin
         port.rdata <= cells[port.addr];
      end
   end
endmodule
`default_nettype wire

// >>> logic/ssr_mem_if.sv
// carrier between the pin control and its storage array
`default_nettype none
interface ssr_mem_if #(
   parameter int ADDR_W = 18,
   parameter int DATA_W = 32,
   parameter int LANES = 4
);
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [LANES-1:0] lane_we;
   logic rd_en;
   logic [DATA_W-1:0] rdata;

   modport ctrl (output addr, output wdata, output lane_we, output rd_en, input rdata);
   modport mem (input addr, input wdata, input lane_we, input rd_en, output rdata);
endinterface
`default_nettype wire

// >>> logic/ssr_params.svh
// constants for the synchronous burst sram pin control block
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// array shape defaults
`define SSR_ADDR_W 18
`define SSR_DATA_W 32
`define SSR_LANE_W 8
`define SSR_LANES 4

// burst counter width and its single increment
`define SSR_CNT_W 2
`define SSR_CNT_STEP 2'h1
`define SSR_CNT_RST 2'h0

// synchroniser depth in front of all pins
`define SSR_SYNC_STAGES 2

// control pins carried through the synchroniser
`define SSR_CTRL_W 12

`endif

// >>> logic/ssr_pkg.sv
// types and helper functions of the burst sram pin control block
`include "ssr_params.svh"
`default_nettype none
package ssr_pkg;

   // gray along desel -> first -> burst, sleep beside desel
   typedef enum logic [1:0] {
      ST_DESEL = 2'b00,
      ST_FIRST = 2'b01,
      ST_BURST = 2'b11,
      ST_SLEEP = 2'b10
   } ssr_state_e;

   typedef logic [`SSR_CNT_W-1:0] ssr_cnt_t;

   // low address bits of a burst beat: linear adds, interleaved xors
   function automatic ssr_cnt_t ssr_burst_ofs(input ssr_cnt_t base, input ssr_cnt_t cnt,
                                              input logic linear);
      ssr_cnt_t ofs;
      ofs = linear ? ssr_cnt_t'(base + cnt) : (base ^ cnt);
      return ofs;
   endfunction

endpackage
`default_nettype wire

// >>> logic/ssr_sram_top.sv
// pin control of a pipelined double-cycle-deselect synchronous burst sram
//
// Operation
// (R1) byte write qualifier sampled each edge; master holds it low for byte writes
// (R2) burst counter steps by one at each edge with advance low
// (R3) processor strobe ignored while primary select is high
// (R4) chip selects evaluated only when a new address loads
// (R5) selected only for primary low, expand-high high, expand-low low
// (R6) without the third select, treat it as always active
// (R7) output enable low drives data pins, high leaves them as inputs
// (R8) first read cycle after deselect keeps outputs off regardless of enable
// (R9) either strobe captures the address and loads its two low bits
// (R10) both strobes low: processor strobe wins, controller strobe ignored
// (R11) sleep high parks the device with data kept; low means normal
// (R12) input data pins captured into a data register at the edge
// (R13) read data appear one cycle after the address edge
// (R14) all-bytes write low writes every lane, overriding byte controls
// (R15) lane selects write their lanes only with the byte qualifier low
// (R16) deselect turns outputs off only after the following edge
// (R17) master keeps output enable high while it drives write data
`include "ssr_params.svh"
`default_nettype none
module ssr_sram_top #(
   parameter int ADDR_W = `SSR_ADDR_W,
   parameter int DATA_W = `SSR_DATA_W,
   parameter int LANES = `SSR_LANES,
   parameter bit HAS_EXPAND_LO = 1'b1
) (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic ARST_N_IN,
   // address and burst control
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic PROCESSOR_ADDR_STROBE_N_IN,
   input wire logic CONTROLLER_ADDR_STROBE_N_IN,
   input wire logic BURST_ADVANCE_N_IN,
   input wire logic LINEAR_BURST_IN,
   // chip selects
   input wire logic SELECT_PRIMARY_N_IN,
   input wire logic SELECT_EXPAND_HI_IN,
   input wire logic SELECT_EXPAND_LO_N_IN,
   // write controls
   input wire logic ALL_BYTES_WRITE_N_IN,
   input wire logic BYTE_WRITE_QUALIFIER_N_IN,
   input wire logic [LANES-1:0] BYTE_LANE_SELECT_N_IN,
   // asynchronous controls
   input wire logic OUTPUT_ENABLE_N_IN,
   input wire logic SLEEP_REQUEST_IN,
   // data pins
   input wire logic [DATA_W-1:0] DQ_IN,
   output logic [DATA_W-1:0] DQ_OUT,
   output logic DQ_OE_OUT,
   // status
   output logic SLEEP_ACTIVE_OUT
);
   localparam int CNT_W = `SSR_CNT_W;
   localparam int SYNC_W = ADDR_W + DATA_W + LANES + `SSR_CTRL_W;

   generate
      if (ADDR_W <= CNT_W || DATA_W != LANES * `SSR_LANE_W) begin : g_bad_shape
         $error("ssr_sram_top: unsupported address or data shape");
      end
   endgenerate

   // ---------------- pin synchroniser ----------------
   // active-low pins are inverted ahead of the first stage so that the reset
   // value of zero means idle on every control; no strobe fires after reset
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;

   assign pin_raw = {
      ADDR_IN,
      DQ_IN,
      ~BYTE_LANE_SELECT_N_IN,
      ~PROCESSOR_ADDR_STROBE_N_IN,
      ~CONTROLLER_ADDR_STROBE_N_IN,
      ~BURST_ADVANCE_N_IN,
      LINEAR_BURST_IN,
      ~SELECT_PRIMARY_N_IN,
      SELECT_EXPAND_HI_IN,
      ~SELECT_EXPAND_LO_N_IN,
      ~ALL_BYTES_WRITE_N_IN,
      ~BYTE_WRITE_QUALIFIER_N_IN,
      ~OUTPUT_ENABLE_N_IN,
      SLEEP_REQUEST_IN,
      1'b0
   };

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   // sampled pins, all active high from here on
   logic [ADDR_W-1:0] s_addr;
   logic [DATA_W-1:0] s_dq;
   logic [LANES-1:0] s_lane_sel;
   logic s_proc_stb;
   logic s_ctrl_stb;
   logic s_adv;
   logic s_linear;
   logic s_sel_pri;
   logic s_sel_hi;
   logic s_sel_lo;
   logic s_all_wr;
   logic s_byte_wr;
   logic s_oe;
   logic s_sleep;
   logic s_spare;

   // (R12) data register
   // the second synchroniser stage is the captured input data register
   assign {s_addr, s_dq, s_lane_sel, s_proc_stb, s_ctrl_stb, s_adv, s_linear,
           s_sel_pri, s_sel_hi, s_sel_lo, s_all_wr, s_byte_wr, s_oe, s_sleep,
           s_spare} = sync2_q;

   // ---------------- access decode ----------------
   ssr_pkg::ssr_state_e state_q;
   ssr_pkg::ssr_state_e state_d;
   logic [ADDR_W-1:0] addr_q;
   ssr_pkg::ssr_cnt_t cnt_q;
   ssr_pkg::ssr_cnt_t cnt_d;
   logic load_proc;
   logic load_ctrl;
   logic load;
   logic selected;
   logic in_burst;
   logic active;
   logic [ADDR_W-1:0] acc_addr;
   ssr_pkg::ssr_cnt_t burst_step;
   logic [LANES-1:0] wr_lanes;
   logic write_go;
   logic read_go;

   // (R3) processor strobe gate
   assign load_proc = s_proc_stb & s_sel_pri & ~s_sleep;
   // (R10) processor strobe priority
   assign load_ctrl = s_ctrl_stb & ~load_proc & ~s_sleep;
   // (R9) either strobe loads
   assign load = load_proc | load_ctrl;

   // (R5) select decode
   // (R6) missing third select active
   assign selected = s_sel_pri & s_sel_hi & (HAS_EXPAND_LO ? s_sel_lo : 1'b1);

   assign in_burst = (state_q == ssr_pkg::ST_FIRST) || (state_q == ssr_pkg::ST_BURST);

   // (R4) selects only on load
   assign active = ~s_sleep & (load ? selected : in_burst);

   // (R14) all lanes override
   // (R15) qualified lane selects
   // (R1) byte qualifier sampled
   always_comb begin
      if (s_all_wr) begin
         wr_lanes = '1;
      end else if (s_byte_wr) begin
         wr_lanes = s_lane_sel;
      end else begin
         wr_lanes = '0;
      end
   end

   // (R2) counter advance
   always_comb begin
      if (load) begin
         cnt_d = s_addr[CNT_W-1:0];
      end else if (in_burst && s_adv && !s_sleep) begin
         cnt_d = ssr_pkg::ssr_cnt_t'(cnt_q + `SSR_CNT_STEP);
      end else begin
         cnt_d = cnt_q;
      end
   end

   // counter holds the linear low bits; the order function wants beats taken so far
   assign burst_step = ssr_pkg::ssr_cnt_t'(cnt_d - addr_q[CNT_W-1:0]);

   // burst beats keep the upper address and reorder the low bits
   always_comb begin
      if (load) begin
         acc_addr = s_addr;
      end else begin
         acc_addr = {addr_q[ADDR_W-1:CNT_W],
                     ssr_pkg::ssr_burst_ofs(addr_q[CNT_W-1:0], burst_step, s_linear)};
      end
   end

   // a processor-strobe load ignores write controls in its own cycle
   assign write_go = active & ~load_proc & (|wr_lanes);
   assign read_go = active & ~write_go;

   // ---------------- state ----------------
   always_comb begin
      case (state_q)
         ssr_pkg::ST_DESEL,
         ssr_pkg::ST_SLEEP: begin
            if (s_sleep) begin
               state_d = ssr_pkg::ST_SLEEP;
            end else if (load && selected) begin
               state_d = ssr_pkg::ST_FIRST;
            end else begin
               state_d = ssr_pkg::ST_DESEL;
            end
         end
         ssr_pkg::ST_FIRST,
         ssr_pkg::ST_BURST: begin
            if (s_sleep) begin
               state_d = ssr_pkg::ST_SLEEP;
            end else if (load && !selected) begin
               state_d = ssr_pkg::ST_DESEL;
            end else begin
               state_d = ssr_pkg::ST_BURST;
            end
         end
         default: begin
            state_d = ssr_pkg::ST_DESEL;
         end
      endcase
   end

   // (R11) sleep parks state
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_q <= ssr_pkg::ST_DESEL;
      end else begin
         state_q <= state_d;
      end
   end

   // (R9) address capture
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         addr_q <= '0;
      end else if (load && selected) begin
         addr_q <= s_addr;
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         cnt_q <= `SSR_CNT_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ---------------- storage ----------------
   ssr_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) mem_bus ();

   assign mem_bus.addr = acc_addr;
   assign mem_bus.wdata = s_dq;
   assign mem_bus.lane_we = write_go ? wr_lanes : '0;
   assign mem_bus.rd_en = read_go;

   ssr_mem #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W),
      .LANES(LANES)
   ) u_mem (
      .clk_in(REF_CLK_IN),
      .port(mem_bus.mem)
   );

   // ---------------- output pipeline ----------------
   logic rd_valid_q;
   logic drive_q;
   logic [DATA_W-1:0] dq_q;

   // (R13) one-cycle read pipeline
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rd_valid_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         rd_valid_q <= read_go;
         drive_q <= rd_valid_q;
      end
   end

   // output register, refreshed only by real read data
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         dq_q <= '0;
      end else if (rd_valid_q) begin
         dq_q <= mem_bus.rdata;
      end
   end

   assign DQ_OUT = dq_q;

   // (R16) double-cycle deselect
   // drive_q trails read_go by two stages, through rd_valid_q, so a deselect edge still
   // leaves the last word on the pins until the edge after it
   logic first_mask;

   // (R8) mask after deselect
   assign first_mask = (state_q == ssr_pkg::ST_FIRST);

   // (R7) enable steers direction
   // a detected write forces the pins off even if the master forgets (R17)
   assign DQ_OE_OUT = drive_q & s_oe & ~first_mask & ~write_go & ~s_sleep;

   assign SLEEP_ACTIVE_OUT = (state_q == ssr_pkg::ST_SLEEP);

endmodule
`default_nettype wire

// >>> verification/ssr_bus_master.sv
// bus master model driving the sram pins
`default_nettype none
module ssr_bus_master (
   // clock
   input wire logic clk_in,
   // pins toward the sram
   output logic [5:0] addr_out,
   output logic [1:0] strobe_n_out,
   output logic adv_n_out,
   output logic [2:0] sel_out,
   output logic gw_n_out,
   output logic bwq_n_out,
   output logic [3:0] lane_n_out,
   output logic oe_n_out,
   output logic [31:0] dq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic quiet = 1'b0;
   logic adv_idle = 1'b1;
   // one pin cycle; strobe bits are {processor, controller}
   task automatic beat(input logic [1:0] st, input logic [2:0] s, input logic [5:0] a,
                       input logic g, input logic q, input logic [3:0] ln,
                       input logic [31:0] d);
      logic wr;
      @(posedge clk_in);
      #2;
      wr = !g || !q;
      strobe_n_out = st;
      adv_n_out = (st == 2'b11) ? adv_idle : 1'b1;
      sel_out = s;
      addr_out = a;
      gw_n_out = g;
      bwq_n_out = q;
      lane_n_out = ln;
      oe_n_out = wr || quiet;
      // released data toggles so stale values never match
      dq_out = wr ? d : ~dq_out;
   endtask
   task automatic idle();
      beat(2'b11, 3'b101, 6'h0, 1'b1, 1'b1, 4'hf, 32'h0);
   endtask
   initial begin
      {strobe_n_out, adv_n_out, gw_n_out, bwq_n_out, oe_n_out} = 6'h3e;
      {sel_out, addr_out, lane_n_out, dq_out} = {3'b101, 6'h0, 4'hf, 32'h0};
   end
endmodule
`default_nettype wire

// >>> verification/ssr_sram_properties.sv
// port assertions of the burst sram pin control
`default_nettype none
module ssr_sram_props #(
   parameter int DATA_W = 32
) (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic ARST_N_IN,
   // watched pins
   input wire logic PROCESSOR_ADDR_STROBE_N_IN,
   input wire logic CONTROLLER_ADDR_STROBE_N_IN,
   input wire logic SELECT_EXPAND_HI_IN,
   input wire logic OUTPUT_ENABLE_N_IN,
   input wire logic SLEEP_REQUEST_IN,
   input wire logic [DATA_W-1:0] DQ_OUT,
   input wire logic DQ_OE_OUT,
   input wire logic SLEEP_ACTIVE_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);
   // pins reach the core two edges late
   property p_oe_pin;
      DQ_OE_OUT |-> !$past(OUTPUT_ENABLE_N_IN, 2);
   endproperty
   a_oe_pin: assert property (p_oe_pin) else $error("drive without enable");
   property p_oe_off;
      OUTPUT_ENABLE_N_IN [*3] |=> !DQ_OE_OUT;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("drive with enable high");
   property p_sleep_on;
      SLEEP_REQUEST_IN [*4] |=> SLEEP_ACTIVE_OUT;
   endproperty
   a_sleep_on: assert property (p_sleep_on) else $error("sleep not entered");
   property p_sleep_off;
      !SLEEP_REQUEST_IN [*4] |=> !SLEEP_ACTIVE_OUT;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("sleep not left");
   property p_sleep_quiet;
      SLEEP_ACTIVE_OUT |-> !DQ_OE_OUT;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("drive in sleep");
   property p_hold;
      $changed(DQ_OUT) && !$past(OUTPUT_ENABLE_N_IN, 2) && !$past(OUTPUT_ENABLE_N_IN, 3)
         |-> DQ_OE_OUT;
   endproperty
   a_hold: assert property (p_hold) else $error("data moved without a read");
   property p_desel;
      !CONTROLLER_ADDR_STROBE_N_IN && PROCESSOR_ADDR_STROBE_N_IN && !SELECT_EXPAND_HI_IN
         |-> ##3 $stable(DQ_OE_OUT) ##1 !DQ_OE_OUT;
   endproperty
   a_desel: assert property (p_desel) else $error("deselect timing wrong");
   property p_reset;
      $rose(ARST_N_IN) |-> !DQ_OE_OUT [*4];
   endproperty
   a_reset: assert property (p_reset) else $error("drive too soon after reset");
   c_sleep: cover property (SLEEP_ACTIVE_OUT);
   c_drive: cover property (DQ_OE_OUT);
   c_both: cover property (!PROCESSOR_ADDR_STROBE_N_IN && !CONTROLLER_ADDR_STROBE_N_IN);
endmodule
bind ssr_sram_top ssr_sram_props #(.DATA_W(DATA_W)) u_props (
   .REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN),
   .PROCESSOR_ADDR_STROBE_N_IN(PROCESSOR_ADDR_STROBE_N_IN),
   .CONTROLLER_ADDR_STROBE_N_IN(CONTROLLER_ADDR_STROBE_N_IN),
   .SELECT_EXPAND_HI_IN(SELECT_EXPAND_HI_IN), .OUTPUT_ENABLE_N_IN(OUTPUT_ENABLE_N_IN),
   .SLEEP_REQUEST_IN(SLEEP_REQUEST_IN), .DQ_OUT(DQ_OUT), .DQ_OE_OUT(DQ_OE_OUT),
   .SLEEP_ACTIVE_OUT(SLEEP_ACTIVE_OUT)
);
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench of the burst sram pin control
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sleep = 1'b0;
   logic linear = 1'b1;
   logic [5:0] addr;
   logic [1:0] st_n;
   logic [2:0] sel;
   logic [3:0] ln;
   logic adv_n, gw_n, bwq_n, oe_n, dq_oe, slp;
   logic [31:0] dq_in, dq_out;
   logic [2:0] dsel [3] = '{3'b110, 3'b000, 3'b011};
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   always #12.5 clk = ~clk;
   ssr_bus_master m (.clk_in(clk), .addr_out(addr), .strobe_n_out(st_n), .adv_n_out(adv_n),
      .sel_out(sel), .gw_n_out(gw_n), .bwq_n_out(bwq_n), .lane_n_out(ln), .oe_n_out(oe_n),
      .dq_out(dq_in));
   ssr_sram_top #(.ADDR_W(6)) DUT (.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(addr),
      .PROCESSOR_ADDR_STROBE_N_IN(st_n[1]), .CONTROLLER_ADDR_STROBE_N_IN(st_n[0]),
      .BURST_ADVANCE_N_IN(adv_n), .LINEAR_BURST_IN(linear), .SELECT_PRIMARY_N_IN(sel[2]),
      .SELECT_EXPAND_HI_IN(sel[1]), .SELECT_EXPAND_LO_N_IN(sel[0]),
      .ALL_BYTES_WRITE_N_IN(gw_n), .BYTE_WRITE_QUALIFIER_N_IN(bwq_n),
      .BYTE_LANE_SELECT_N_IN(ln), .OUTPUT_ENABLE_N_IN(oe_n), .SLEEP_REQUEST_IN(sleep),
      .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_OUT(dq_oe), .SLEEP_ACTIVE_OUT(slp));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // pins two edges late: load three edges after the beat, word and drive one edge later
   task automatic rd(input logic [1:0] st, input logic [2:0] s, input logic [5:0] a,
                     input logic g, input logic fresh, input logic [31:0] ed, input logic eo);
      m.beat(st, s, a, g, 1'b1, 4'hf, 32'h0);
      repeat (3) m.idle();
      if (fresh)
         chk("mask", 32'h0, {31'h0, dq_oe});
      m.idle();
      chk("drive", {31'h0, eo}, {31'h0, dq_oe});
      if (eo)
         chk("data", ed, dq_out);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #2 rst_n = 1'b1;
      m.beat(2'b10, 3'b010, 6'h5, 1'b0, 1'b1, 4'hf, 32'h11223344);
      rd(2'b10, 3'b010, 6'h5, 1'b1, 1'b0, 32'h11223344, 1'b1);
      m.beat(2'b10, 3'b010, 6'h5, 1'b1, 1'b0, 4'b1110, 32'haabbccdd);
      m.beat(2'b10, 3'b010, 6'h5, 1'b1, 1'b1, 4'h0, 32'h0);
      rd(2'b10, 3'b010, 6'h5, 1'b1, 1'b0, 32'h112233dd, 1'b1);
      for (int i = 0; i < 4; i++)
         m.beat(2'b10, 3'b010, 6'(8 + i), 1'b0, 1'b1, 4'hf, 32'(8 + i));
      m.adv_idle = 1'b0;
      rd(2'b10, 3'b010, 6'h9, 1'b1, 1'b0, 32'h9, 1'b1);
      for (int i = 1; i < 4; i++) begin
         m.idle();
         chk("beat", 32'(8 + (1 + i) % 4), dq_out);
      end
      linear = 1'b0;
      rd(2'b10, 3'b010, 6'h9, 1'b1, 1'b0, 32'h9, 1'b1);
      for (int i = 1; i < 4; i++) begin
         m.idle();
         chk("xor beat", 32'(8 + (1 ^ i)), dq_out);
      end
      linear = 1'b1;
      m.adv_idle = 1'b1;
      rd(2'b00, 3'b010, 6'h9, 1'b0, 1'b0, 32'h9, 1'b1);
      rd(2'b01, 3'b110, 6'h5, 1'b1, 1'b0, 32'h9, 1'b1);
      foreach (dsel[i]) begin
         rd(2'b10, dsel[i], 6'h5, 1'b1, 1'b0, 32'h0, 1'b0);
         rd(2'b10, 3'b010, 6'h9, 1'b1, 1'b1, 32'h9, 1'b1);
      end
      m.quiet = 1'b1;
      repeat (4) m.idle();
      chk("oe high", 32'h0, {31'h0, dq_oe});
      m.quiet = 1'b0;
      repeat (4) m.idle();
      chk("oe low", 32'h1, {31'h0, dq_oe});
      sleep = 1'b1;
      repeat (5) m.idle();
      chk("sleep", 32'h1, {31'h0, slp});
      sleep = 1'b0;
      repeat (5) m.idle();
      chk("wake", 32'h0, {31'h0, slp});
      rd(2'b10, 3'b010, 6'h5, 1'b1, 1'b1, 32'h112233dd, 1'b1);
      report_and_stop();
   end
   // hang guard, far above the hundred or so cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         report_and_stop();
      end
   end
endmodule
`default_nettype wire
